//--- logic/cce_regs.vh
`ifndef CCE_REGS_VH
`define CCE_REGS_VH
// ==========================================
// Register offsets
`define CCE_OFF_CT_START 12'h014
`define CCE_OFF_CT_STOP 12'h018
`define CCE_OFF_XO_STARTED 12'h100
`define CCE_OFF_SLOW_STARTED 12'h104
`define CCE_OFF_CAL_DONE 12'h10c
`define CCE_OFF_CT_TIMEOUT 12'h110
`define CCE_OFF_CT_STARTED 12'h128
`define CCE_OFF_CT_STOPPED 12'h12c
`define CCE_OFF_IRQ_ENSET 12'h304
`define CCE_OFF_IRQ_ENCLR 12'h308
// ==========================================
// Field positions in the enable registers
`define CCE_BIT_XO_STARTED 0
`define CCE_BIT_SLOW_STARTED 1
`define CCE_BIT_CAL_DONE 2
`define CCE_BIT_CT_TIMEOUT 3
`define CCE_BIT_CT_STARTED 4
`define CCE_BIT_CT_STOPPED 5
`define CCE_NUM_EVENTS 6
// ==========================================
// Reset values
`define CCE_RST_EVENTS 6'h00
`define CCE_RST_ENABLE 6'h00
// ==========================================
// Timing counts
`define CCE_CT_SETTLE_CYCLES 4'h2
`endif

//--- logic/cce_evflag.v
`timescale 1ns/1ns
// Sticky event flag: hardware set wins over software clear
module cce_evflag (
	input wire clk,
	input wire rst_n,
	input wire set_pulse,
	input wire sw_write,
	input wire sw_value,
	output reg flag_r
);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= 1'b0;
		end else if (set_pulse) begin
			flag_r <= 1'b1;
		end else if (sw_write) begin
			flag_r <= sw_value;
		end
	end
endmodule

//--- logic/cce_top.v
`timescale 1ns/1ns
`include "cce_regs.vh"
// Operation
// - Writing one to offset 0x014 starts the calibration timer.
// - Writing one to offset 0x018 stops the calibration timer.
// - Flag at 0x100 reads one once crystal oscillator started.
// - Flag at 0x10C set when RC oscillator calibration completes.
// - Flag at 0x128 set once timer started and accepts new tasks.
// - Flag at 0x12C set once timer stopped and accepts new tasks.
// - Per-event interrupt enable, set by writing one, readable.
module cce_top #(
	parameter CT_SETTLE = `CCE_CT_SETTLE_CYCLES
) (
	input wire CLK,
	input wire RSTN,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [11:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	output reg WB_ERR_O,
	input wire XO_STARTED,
	input wire SLOW_CLOCK_STARTED,
	input wire CAL_DONE,
	input wire CT_TIMEOUT,
	output reg CT_START,
	output reg CT_STOP,
	output reg CT_RUNNING,
	output reg IRQ
);
	// ==========================================
	// Input synchronisers and edge detect
	reg [3:0] sync1_r;
	reg [3:0] sync2_r;
	reg [3:0] sync3_r;
	wire [3:0] ext_rise;
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			sync3_r <= 4'h0;
		end else begin
			sync1_r <= {CT_TIMEOUT, CAL_DONE, SLOW_CLOCK_STARTED, XO_STARTED};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	assign ext_rise = sync2_r & ~sync3_r;

	// ==========================================
	// Bus decode
	wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
	wire wr = req && WB_WE_I && WB_SEL_I[0];
	wire bit0 = WB_DAT_I[0];
	localparam SEL_CT_START = 0;
	localparam SEL_CT_STOP = 1;
	localparam SEL_XO_STARTED = 2;
	localparam SEL_SLOW_STARTED = 3;
	localparam SEL_CAL_DONE = 4;
	localparam SEL_CT_TIMEOUT = 5;
	localparam SEL_CT_STARTED = 6;
	localparam SEL_CT_STOPPED = 7;
	localparam SEL_IRQ_ENSET = 8;
	localparam SEL_IRQ_ENCLR = 9;
	wire [9:0] dec;
	wire hit;

	// One-hot register select, all zero for an unmapped offset
	function [9:0] reg_sel;
		input [11:0] a;
		begin
			reg_sel = 10'h000;
			if (a == `CCE_OFF_CT_START) begin
				reg_sel[SEL_CT_START] = 1'b1;
			end else if (a == `CCE_OFF_CT_STOP) begin
				reg_sel[SEL_CT_STOP] = 1'b1;
			end else if (a == `CCE_OFF_XO_STARTED) begin
				reg_sel[SEL_XO_STARTED] = 1'b1;
			end else if (a == `CCE_OFF_SLOW_STARTED) begin
				reg_sel[SEL_SLOW_STARTED] = 1'b1;
			end else if (a == `CCE_OFF_CAL_DONE) begin
				reg_sel[SEL_CAL_DONE] = 1'b1;
			end else if (a == `CCE_OFF_CT_TIMEOUT) begin
				reg_sel[SEL_CT_TIMEOUT] = 1'b1;
			end else if (a == `CCE_OFF_CT_STARTED) begin
				reg_sel[SEL_CT_STARTED] = 1'b1;
			end else if (a == `CCE_OFF_CT_STOPPED) begin
				reg_sel[SEL_CT_STOPPED] = 1'b1;
			end else if (a == `CCE_OFF_IRQ_ENSET) begin
				reg_sel[SEL_IRQ_ENSET] = 1'b1;
			end else if (a == `CCE_OFF_IRQ_ENCLR) begin
				reg_sel[SEL_IRQ_ENCLR] = 1'b1;
			end
		end
	endfunction

	assign dec = reg_sel(WB_ADR_I);
	assign hit = |dec;

	// ==========================================
	// Settle countdown arithmetic
	function settle_last;
		input [3:0] cnt;
		begin
			settle_last = (cnt <= 4'h1);
		end
	endfunction

	function [3:0] settle_step;
		input [3:0] cnt;
		begin
			settle_step = cnt - 4'h1;
		end
	endfunction

	// ==========================================
	// Task triggers and calibration timer handshake
	wire start_task = wr && bit0 && dec[SEL_CT_START];
	wire stop_task = wr && bit0 && dec[SEL_CT_STOP];
	localparam ST_IDLE = 3'b001;
	localparam ST_STARTING = 3'b010;
	localparam ST_STOPPING = 3'b100;
	reg [2:0] state_r;
	reg [3:0] settle_r;
	reg started_pulse_r;
	reg stopped_pulse_r;
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= ST_IDLE;
			settle_r <= 4'h0;
			started_pulse_r <= 1'b0;
			stopped_pulse_r <= 1'b0;
			CT_START <= 1'b0;
			CT_STOP <= 1'b0;
			CT_RUNNING <= 1'b0;
		end else begin
			started_pulse_r <= 1'b0;
			stopped_pulse_r <= 1'b0;
			CT_START <= 1'b0;
			CT_STOP <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (stop_task) begin
						CT_STOP <= 1'b1;
						state_r <= ST_STOPPING;
						settle_r <= CT_SETTLE[3:0];
					end else if (start_task) begin
						CT_START <= 1'b1;
						state_r <= ST_STARTING;
						settle_r <= CT_SETTLE[3:0];
					end
				end
				ST_STARTING: begin
					if (settle_last(settle_r)) begin
						CT_RUNNING <= 1'b1;
						started_pulse_r <= 1'b1;
						state_r <= ST_IDLE;
					end else begin
						settle_r <= settle_step(settle_r);
					end
				end
				ST_STOPPING: begin
					if (settle_last(settle_r)) begin
						CT_RUNNING <= 1'b0;
						stopped_pulse_r <= 1'b1;
						state_r <= ST_IDLE;
					end else begin
						settle_r <= settle_step(settle_r);
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Event flags
	wire [5:0] ev_set = {stopped_pulse_r, started_pulse_r, ext_rise};
	wire [5:0] ev_wr;
	wire [5:0] flags;
	assign ev_wr[`CCE_BIT_XO_STARTED] = wr && dec[SEL_XO_STARTED];
	assign ev_wr[`CCE_BIT_SLOW_STARTED] = wr && dec[SEL_SLOW_STARTED];
	assign ev_wr[`CCE_BIT_CAL_DONE] = wr && dec[SEL_CAL_DONE];
	assign ev_wr[`CCE_BIT_CT_TIMEOUT] = wr && dec[SEL_CT_TIMEOUT];
	assign ev_wr[`CCE_BIT_CT_STARTED] = wr && dec[SEL_CT_STARTED];
	assign ev_wr[`CCE_BIT_CT_STOPPED] = wr && dec[SEL_CT_STOPPED];

	cce_evflag u_xo_flag (
		.clk(CLK),
		.rst_n(RSTN),
		.set_pulse(ev_set[`CCE_BIT_XO_STARTED]),
		.sw_write(ev_wr[`CCE_BIT_XO_STARTED]),
		.sw_value(bit0),
		.flag_r(flags[`CCE_BIT_XO_STARTED])
	);

	cce_evflag u_slow_flag (
		.clk(CLK),
		.rst_n(RSTN),
		.set_pulse(ev_set[`CCE_BIT_SLOW_STARTED]),
		.sw_write(ev_wr[`CCE_BIT_SLOW_STARTED]),
		.sw_value(bit0),
		.flag_r(flags[`CCE_BIT_SLOW_STARTED])
	);

	cce_evflag u_cal_flag (
		.clk(CLK),
		.rst_n(RSTN),
		.set_pulse(ev_set[`CCE_BIT_CAL_DONE]),
		.sw_write(ev_wr[`CCE_BIT_CAL_DONE]),
		.sw_value(bit0),
		.flag_r(flags[`CCE_BIT_CAL_DONE])
	);

	cce_evflag u_timeout_flag (
		.clk(CLK),
		.rst_n(RSTN),
		.set_pulse(ev_set[`CCE_BIT_CT_TIMEOUT]),
		.sw_write(ev_wr[`CCE_BIT_CT_TIMEOUT]),
		.sw_value(bit0),
		.flag_r(flags[`CCE_BIT_CT_TIMEOUT])
	);

	cce_evflag u_started_flag (
		.clk(CLK),
		.rst_n(RSTN),
		.set_pulse(ev_set[`CCE_BIT_CT_STARTED]),
		.sw_write(ev_wr[`CCE_BIT_CT_STARTED]),
		.sw_value(bit0),
		.flag_r(flags[`CCE_BIT_CT_STARTED])
	);

	cce_evflag u_stopped_flag (
		.clk(CLK),
		.rst_n(RSTN),
		.set_pulse(ev_set[`CCE_BIT_CT_STOPPED]),
		.sw_write(ev_wr[`CCE_BIT_CT_STOPPED]),
		.sw_value(bit0),
		.flag_r(flags[`CCE_BIT_CT_STOPPED])
	);

	// ==========================================
	// Interrupt enables
	reg [5:0] irq_en_r;
	wire [5:0] pending = flags & irq_en_r;
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_en_r <= `CCE_RST_ENABLE;
		end else begin
			if (wr && dec[SEL_IRQ_ENSET]) begin
				irq_en_r <= irq_en_r | WB_DAT_I[5:0];
			end else if (wr && dec[SEL_IRQ_ENCLR]) begin
				irq_en_r <= irq_en_r & ~WB_DAT_I[5:0];
			end
		end
	end

	// Level interrupt while any enabled flag stands
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |pending;
		end
	end

	// ==========================================
	// Read mux and acknowledge
	reg [31:0] rd_nxt;
	always @* begin
		rd_nxt = 32'h0000_0000;
		if (dec[SEL_XO_STARTED]) begin
			rd_nxt[0] = flags[`CCE_BIT_XO_STARTED];
		end else if (dec[SEL_SLOW_STARTED]) begin
			rd_nxt[0] = flags[`CCE_BIT_SLOW_STARTED];
		end else if (dec[SEL_CAL_DONE]) begin
			rd_nxt[0] = flags[`CCE_BIT_CAL_DONE];
		end else if (dec[SEL_CT_TIMEOUT]) begin
			rd_nxt[0] = flags[`CCE_BIT_CT_TIMEOUT];
		end else if (dec[SEL_CT_STARTED]) begin
			rd_nxt[0] = flags[`CCE_BIT_CT_STARTED];
		end else if (dec[SEL_CT_STOPPED]) begin
			rd_nxt[0] = flags[`CCE_BIT_CT_STOPPED];
		end else if (dec[SEL_IRQ_ENSET] || dec[SEL_IRQ_ENCLR]) begin
			rd_nxt[5:0] = irq_en_r;
		end else if (dec[SEL_CT_START] || dec[SEL_CT_STOP]) begin
			// Write-only triggers read back as zero
			rd_nxt = 32'h0000_0000;
		end
	end

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			WB_ACK_O <= 1'b0;
			WB_ERR_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req && hit;
			WB_ERR_O <= req && !hit;
			WB_DAT_O <= req ? rd_nxt : 32'h0000_0000;
		end
	end
endmodule

//--- test/cce_top_checker.sv
`timescale 1ns/1ns
module cce_top_checker (
	input wire CLK,
	input wire RSTN,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [11:0] WB_ADR_I,
	input wire [31:0] WB_DAT_I,
	input wire [31:0] WB_DAT_O,
	input wire WB_ACK_O,
	input wire WB_ERR_O,
	input wire CT_START,
	input wire CT_STOP,
	input wire CT_RUNNING
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence s_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
	endsequence
	chk_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack wider than one cycle");
	chk_enset_ack: assert property (s_req ##0 WB_ADR_I == 12'h304 |=> WB_ACK_O)
		else $error("enable access not acked");
	chk_hole_err: assert property (s_req ##0 WB_ADR_I == 12'h200 |=> WB_ERR_O)
		else $error("unmapped access not refused");
	chk_start_cause: assert property (CT_START |-> $past(WB_WE_I && WB_ADR_I == 12'h014 && WB_DAT_I[0]))
		else $error("start without start write");
	chk_stop_cause: assert property (CT_STOP |-> $past(WB_WE_I && WB_ADR_I == 12'h018 && WB_DAT_I[0]))
		else $error("stop without stop write");
	chk_start_run: assert property (CT_START |-> ##[2:3] CT_RUNNING)
		else $error("timer not running");
	chk_stop_run: assert property (CT_STOP |-> ##[2:3] !CT_RUNNING)
		else $error("timer still running");
	chk_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
		else $error("read data outside ack");
endmodule
bind cce_top cce_top_checker u_chk (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .CT_START(CT_START),
	.CT_STOP(CT_STOP), .CT_RUNNING(CT_RUNNING));

//--- test/cce_top_test.sv
`timescale 1ns/1ns
module cce_top_test;
	reg clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
	reg [11:0] adr = 0;
	reg [31:0] dat = 0;
	reg [3:0] ev = 0;
	reg [3:0] sel = 4'hf, sm = 4'hf;
	wire [31:0] dato;
	wire ack, err, cs, cp, run, irq;
	integer err_count = 0, check_count = 0, i, r;
	reg [33:0] q[$];
	reg [33:0] h;
	reg [11:0] fa[0:3] = '{12'h100, 12'h104, 12'h10c, 12'h110};
	always #2 clk = ~clk;
	cce_top dut (.CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack),
		.WB_ERR_O(err), .XO_STARTED(ev[0]), .SLOW_CLOCK_STARTED(ev[1]), .CAL_DONE(ev[2]),
		.CT_TIMEOUT(ev[3]), .CT_START(cs), .CT_STOP(cp), .CT_RUNNING(run), .IRQ(irq));
	task chk(input [31:0] s, input [31:0] x, input string n);
		begin
			check_count = check_count + 1;
			if (s !== x) begin
				err_count = err_count + 1;
				$display("CHECK FAILED %s exp %h seen %h", n, x, s);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task wb(input w, input [11:0] a, input [31:0] d, input e, input [31:0] x);
		integer n;
		begin
			q.push_back({w, e, x});
			@(posedge clk);
			cyc <= 1;
			stb <= 1;
			we <= w;
			adr <= a;
			dat <= d;
			sel <= sm;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (ack !== 1 && err !== 1 && n < 20);
			cyc <= 0;
			stb <= 0;
			if (ack !== 1 && err !== 1) begin
				err_count = err_count + 1;
				end_of_test;
			end
		end
	endtask
	// Oldest note against each answer
	always @(posedge clk) begin
		if (ack === 1 || err === 1) begin
			h = q.pop_front();
			chk(err, h[32], "err");
			if (!h[33])
				chk(dato, h[31:0], "rdata");
		end
	end
	initial begin
		r = $urandom(1);
		repeat (12) @(posedge clk);
		rstn <= 1;
		for (i = 0; i < 4; i = i + 1)
			wb(0, fa[i], 0, 0, 0);
		wb(0, 12'h128, 0, 0, 0);
		wb(0, 12'h304, 0, 0, 0);
		$display("reset values done");
		for (i = 0; i < 4; i = i + 1) begin
			ev[i] <= 1;
			repeat (5) @(posedge clk);
			wb(0, fa[i], 0, 0, 1);
			ev[i] <= 0;
			wb(1, fa[i], 0, 0, 0);
			wb(0, fa[i], 0, 0, 0);
		end
		$display("event flags done");
		wb(1, 12'h304, 1, 0, 0);
		wb(0, 12'h304, 0, 0, 1);
		ev[0] <= 1;
		repeat (6) @(posedge clk);
		chk(irq, 1, "irq");
		wb(1, 12'h308, 1, 0, 0);
		repeat (2) @(posedge clk);
		chk(irq, 0, "irq masked");
		wb(1, 12'h100, 0, 0, 0);
		ev[0] <= 0;
		wb(1, 12'h304, 1, 0, 0);
		repeat (2) @(posedge clk);
		chk(irq, 0, "irq cleared");
		$display("interrupt done");
		wb(1, 12'h014, 1, 0, 0);
		chk(cs, 1, "start pulse");
		wb(1, 12'h018, 0, 0, 0);
		chk(cp, 0, "stop by zero");
		repeat (4) @(posedge clk);
		chk(run, 1, "running");
		wb(0, 12'h128, 0, 0, 1);
		wb(0, 12'h12c, 0, 0, 0);
		wb(1, 12'h018, 1, 0, 0);
		chk(cp, 1, "stop pulse");
		repeat (4) @(posedge clk);
		chk(run, 0, "stopped");
		wb(0, 12'h12c, 0, 0, 1);
		wb(0, 12'h200, 0, 1, 0);
		wb(1, 12'h108, 1, 1, 0);
		$display("timer done");
		for (i = 0; i < 6; i = i + 1) begin
			r = $urandom;
			wb(1, 12'h308, 32'h3f, 0, 0);
			wb(1, 12'h304, r, 0, 0);
			wb(0, 12'h308, 0, 0, r & 32'h3f);
		end
		$display("random enables done");
		wb(1, 12'h308, 32'h3f, 0, 0);
		sm = 4'he;
		wb(1, 12'h304, 32'h3f, 0, 0);
		sm = 4'hf;
		wb(0, 12'h304, 0, 0, 0);
		$display("lane select done");
		end_of_test;
	end
endmodule
